// ---- shared/slerr_pkg.sv ----
package slerr_pkg;
	// secondary error codes
	localparam logic [7:0] CODE_NONE       = 8'h00;
	localparam logic [7:0] CODE_NO_EOT     = 8'h15;
	localparam logic [7:0] CODE_NO_ACKNAK  = 8'h16;
	localparam logic [7:0] CODE_MST_ENQ    = 8'h17;
	localparam logic [7:0] CODE_PEER_NAK   = 8'h18;
	localparam logic [7:0] CODE_PEER_ENQ   = 8'h19;
	localparam logic [7:0] CODE_CTS_TMO    = 8'h1a;
	localparam logic [7:0] CODE_CPU_XFER   = 8'h1d;
	localparam logic [7:0] CODE_HDR_LINE   = 8'h1e;
	localparam logic [7:0] CODE_DATA_LINE  = 8'h1f;
	localparam logic [7:0] CODE_PORT_BUSY  = 8'h30;
	localparam logic [7:0] CODE_BAD_CMD    = 8'h41;
	localparam logic [7:0] CODE_BAD_LEN    = 8'h42;
	localparam logic [7:0] CODE_NOT_PEER   = 8'h44;
	localparam logic [7:0] CODE_NOT_SLAVE  = 8'h45;
	localparam logic [7:0] CODE_MST_ONLY   = 8'h46;
	localparam logic [7:0] CODE_BAD_TARGET = 8'h47;
	localparam logic [7:0] CODE_RANGE      = 8'h48;
	localparam logic [7:0] CODE_GENERIC    = 8'h7f;
	// retry limit when none configured
	localparam logic [7:0] ENQ_LIMIT_DFLT  = 8'h20;
	// cts timeout: 1 ms at 125 MHz
	localparam int         CTS_TMO_US      = 1000;
	localparam int         CLK_MHZ         = 125;
	localparam int         CTS_TMO_CYC     = CTS_TMO_US * CLK_MHZ;
	localparam int         CNT_W           = 8;
	// port roles
	typedef enum logic [1:0] {SLERR_MASTER, SLERR_SLAVE, SLERR_PEER} slerr_role_t;
	// command permission classes
	typedef enum logic [1:0] {SLERR_ANY, SLERR_MST_ONLY_CMD, SLERR_NO_PEER, SLERR_NO_SLAVE}
		slerr_perm_t;
	// link phases, merged onto one enum
	typedef enum logic [2:0] {SLERR_LS_IDLE, SLERR_LS_ENQ, SLERR_LS_HDR, SLERR_LS_DATA,
		SLERR_LS_WAIT_ACK, SLERR_LS_WAIT_EOT} slerr_lstate_t;
endpackage : slerr_pkg

// ---- shared/slerr_enq_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface slerr_enq_if;
	logic       clr;
	logic       inc;
	logic [7:0] limit;
	logic       hit;
	modport owner (output clr, output inc, output limit, input hit);
	modport cnt   (input clr, input inc, input limit, output hit);
endinterface : slerr_enq_if
`default_nettype wire

// ---- design/slerr_retry_cnt.sv ----
`timescale 1ns/1ps
`default_nettype none
module slerr_retry_cnt
	import slerr_pkg::*;
#(
	parameter int W = CNT_W
) (
	input  wire logic  i_clk,
	input  wire logic  i_rst_n,
	slerr_enq_if.cnt   port
);
	logic [W-1:0] count;
	logic [W-1:0] next_count;

	always_comb begin
		next_count = count;
		if (port.clr)
			next_count = '0;
		else if (port.inc && count != {W{1'b1}})
			next_count = count + W'(1);
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			count <= '0;
		else
			count <= next_count;
	end

	// the attempt that reaches the limit is the one that aborts
	assign port.hit = port.inc && (next_count >= port.limit);
endmodule : slerr_retry_cnt
`default_nettype wire

// ---- design/slerr_reporter.sv ----
`timescale 1ns/1ps
`default_nettype none
module slerr_reporter
	import slerr_pkg::*;
#(
	parameter int CTS_CYCLES = CTS_TMO_CYC
) (
	// clock and reset
	input  wire logic                  i_clk,
	input  wire logic                  i_rst_n,
	// port configuration
	input  wire slerr_pkg::slerr_role_t i_role,
	input  wire logic [7:0]            i_enq_limit,
	// command request from the controller, decoded fields
	input  wire logic                  i_req_valid,
	input  wire logic                  i_req_starts_conv,
	input  wire logic                  i_req_cmd_known,
	input  wire slerr_pkg::slerr_perm_t i_req_perm,
	input  wire logic                  i_req_len_ok,
	input  wire logic                  i_req_target_ok,
	input  wire logic                  i_req_values_ok,
	// protocol engine events, same clock
	input  wire logic                  i_conv_done,
	input  wire slerr_pkg::slerr_lstate_t i_phase,
	input  wire logic                  i_phase_timeout,
	input  wire logic                  i_enq_sent,
	input  wire logic                  i_ack_rx,
	input  wire logic                  i_nak_rx,
	input  wire logic                  i_line_err,
	input  wire logic                  i_cpu_xfer_err,
	input  wire logic                  i_misc_err,
	input  wire logic                  i_tx_pending,
	// serial pin
	input  wire logic                  i_cts,
	// results
	output logic                       o_req_accept,
	output logic                       o_err_valid,
	output logic                       o_abort,
	output logic                       o_port_busy,
	output logic [15:0]                o_status_word,
	output logic [15:0]                o_diag_word
);
	logic        rst_s1, rst_s2, rst_n;
	logic        cts_s1, cts_s2;
	logic        busy, next_busy;
	logic [7:0]  code, next_code;
	logic        err_v, next_err_v;
	logic        acc, next_acc;
	logic        abrt, next_abrt;
	logic [31:0] cts_cnt, next_cts_cnt;
	logic [7:0]  req_code, link_code, limit;
	logic        mst_hit, nak_hit, nore_hit;

	slerr_enq_if mst_if ();
	slerr_enq_if nak_if ();
	slerr_enq_if nore_if ();

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rst_s1 <= 1'b0;
			rst_s2 <= 1'b0;
		end else begin
			rst_s1 <= 1'b1;
			rst_s2 <= rst_s1;
		end
	end
	assign rst_n = rst_s2;

	// cts is a pin: only the second stage is read
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			cts_s1 <= 1'b0;
			cts_s2 <= 1'b0;
		end else begin
			cts_s1 <= i_cts;
			cts_s2 <= cts_s1;
		end
	end

	// zero from software means "not configured"
	assign limit = (i_enq_limit == 8'h00) ? ENQ_LIMIT_DFLT : i_enq_limit;

	assign mst_if.clr    = (i_conv_done || !busy);
	assign mst_if.inc    = (i_role == SLERR_MASTER) && i_enq_sent && i_phase_timeout;
	assign mst_if.limit  = limit;
	assign nak_if.clr    = (i_conv_done || !busy);
	assign nak_if.inc    = (i_role == SLERR_PEER) && (i_phase == SLERR_LS_ENQ) && i_nak_rx;
	assign nak_if.limit  = limit;
	assign nore_if.clr   = (i_conv_done || !busy);
	assign nore_if.inc   = (i_role == SLERR_PEER) && i_enq_sent && i_phase_timeout;
	assign nore_if.limit = limit;
	assign mst_hit  = mst_if.hit;
	assign nak_hit  = nak_if.hit;
	assign nore_hit = nore_if.hit;

	slerr_retry_cnt #(.W(CNT_W)) u_mst  (.i_clk(i_clk), .i_rst_n(rst_n), .port(mst_if));
	slerr_retry_cnt #(.W(CNT_W)) u_nak  (.i_clk(i_clk), .i_rst_n(rst_n), .port(nak_if));
	slerr_retry_cnt #(.W(CNT_W)) u_nore (.i_clk(i_clk), .i_rst_n(rst_n), .port(nore_if));

	// request checks, in order of precedence
	always_comb begin
		req_code = CODE_NONE;
		if (!i_req_cmd_known)
			req_code = CODE_BAD_CMD;
		else if (i_req_perm == SLERR_NO_PEER && i_role == SLERR_PEER)
			req_code = CODE_NOT_PEER;
		else if (i_req_perm == SLERR_NO_SLAVE && i_role == SLERR_SLAVE)
			req_code = CODE_NOT_SLAVE;
		else if (i_req_perm == SLERR_MST_ONLY_CMD && i_role != SLERR_MASTER)
			req_code = CODE_MST_ONLY;
		else if (!i_req_len_ok)
			req_code = CODE_BAD_LEN;
		else if (!i_req_target_ok)
			req_code = CODE_BAD_TARGET;
		else if (!i_req_values_ok)
			req_code = CODE_RANGE;
		else if (i_req_starts_conv && busy)
			req_code = CODE_PORT_BUSY;
	end

	// link events; retry aborts outrank single-event faults
	always_comb begin
		link_code = CODE_NONE;
		if (mst_hit)
			link_code = CODE_MST_ENQ;
		else if (nak_hit)
			link_code = CODE_PEER_NAK;
		else if (nore_hit)
			link_code = CODE_PEER_ENQ;
		else if (i_tx_pending && cts_cnt >= 32'(CTS_CYCLES - 1) && !cts_s2)
			link_code = CODE_CTS_TMO;
		else if (i_cpu_xfer_err)
			link_code = CODE_CPU_XFER;
		else if (i_line_err && i_phase == SLERR_LS_HDR)
			link_code = CODE_HDR_LINE;
		else if (i_line_err && i_phase == SLERR_LS_DATA)
			link_code = CODE_DATA_LINE;
		else if (i_phase_timeout && i_phase == SLERR_LS_WAIT_EOT)
			link_code = CODE_NO_EOT;
		else if (i_phase_timeout && i_phase == SLERR_LS_WAIT_ACK)
			link_code = CODE_NO_ACKNAK;
		else if (i_misc_err || i_line_err)
			link_code = CODE_GENERIC;
	end

	always_comb begin
		next_busy    = busy;
		next_code    = code;
		next_err_v   = 1'b0;
		next_acc     = 1'b0;
		next_abrt    = 1'b0;
		next_cts_cnt = 32'h0;
		if (i_tx_pending && !cts_s2 && cts_cnt < 32'(CTS_CYCLES - 1))
			next_cts_cnt = cts_cnt + 32'h1;
		if (i_conv_done)
			next_busy = 1'b0;
		if (busy && link_code != CODE_NONE) begin
			next_code  = link_code;
			next_err_v = 1'b1;
			next_abrt  = 1'b1;
			next_busy  = 1'b0;
		end
		// a new request wins the reported code over a link fault in the same cycle
		if (i_req_valid) begin
			next_code  = req_code;
			next_err_v = (req_code != CODE_NONE);
			next_acc   = (req_code == CODE_NONE);
			if (req_code == CODE_NONE && i_req_starts_conv)
				next_busy = 1'b1;
		end
	end

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			busy    <= 1'b0;
			code    <= CODE_NONE;
			err_v   <= 1'b0;
			acc     <= 1'b0;
			abrt    <= 1'b0;
			cts_cnt <= 32'h0;
		end else begin
			busy    <= next_busy;
			code    <= next_code;
			err_v   <= next_err_v;
			acc     <= next_acc;
			abrt    <= next_abrt;
			cts_cnt <= next_cts_cnt;
		end
	end

	always_comb begin
		o_req_accept  = acc;
		o_err_valid   = err_v;
		o_abort       = abrt;
		o_port_busy   = busy;
		o_status_word = {code, 8'h00};
		o_diag_word   = {8'h00, code};
	end

	chk_busy_reject: assert property (@(posedge i_clk) disable iff (!rst_n)
		(i_req_valid && i_req_starts_conv && busy && i_req_cmd_known && i_req_perm == SLERR_ANY
		&& i_req_len_ok && i_req_target_ok && i_req_values_ok) |=> (code == CODE_PORT_BUSY && err_v))
		else $error("busy port request not rejected");
	chk_bad_cmd: assert property (@(posedge i_clk) disable iff (!rst_n)
		(i_req_valid && !i_req_cmd_known) |=> (code == CODE_BAD_CMD && !acc))
		else $error("unknown command not flagged");
	chk_word_mirror: assert property (@(posedge i_clk) disable iff (!rst_n)
		o_status_word[15:8] == o_diag_word[7:0])
		else $error("status and diagnostic codes differ");
	chk_err_code: assert property (@(posedge i_clk) disable iff (!rst_n)
		err_v |-> (code != CODE_NONE && code <= CODE_GENERIC))
		else $error("error pulse without code");
	chk_master_role: assert property (@(posedge i_clk) disable iff (!rst_n)
		(i_req_valid && i_req_cmd_known && i_req_perm == SLERR_MST_ONLY_CMD
		&& i_role != SLERR_MASTER) |=> code == CODE_MST_ONLY)
		else $error("master-only command accepted");
	chk_cpu_xfer: assert property (@(posedge i_clk) disable iff (!rst_n)
		(busy && i_cpu_xfer_err && !i_req_valid && !mst_hit && !nak_hit && !nore_hit
		&& !(i_tx_pending && !cts_s2)) |=> (code == CODE_CPU_XFER && err_v && abrt))
		else $error("controller transfer fault not reported");
endmodule : slerr_reporter
`default_nettype wire

// ---- testbench/slerr_peer_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module slerr_peer_model (
	// control from the bench
	input  wire logic i_clk,
	input  wire logic i_nak_cmd,
	input  wire logic i_cts_block,
	// line events toward the block
	output logic      o_nak,
	output logic      o_cts
);
	// the peer answers one clock later, never in the same cycle
	always_ff @(posedge i_clk) o_nak <= i_nak_cmd;
	// cts drops only while the bench blocks the line
	assign o_cts = ~i_cts_block;
endmodule : slerr_peer_model
`default_nettype wire

// ---- testbench/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import slerr_pkg::*;
	typedef struct packed {logic abt; logic [7:0] code;} slerr_note_t;
	logic          clk, rst_n, rv, st, kn, lok, tok, vok, done, tmo, enq, le, ce, me, tx;
	logic          nakc, blk, nak, cts, acc, ev, ab, busy;
	logic [7:0]    lim;
	logic [15:0]   sw, dw;
	slerr_role_t   role;
	slerr_perm_t   perm;
	slerr_lstate_t ph;
	slerr_note_t   q[$];
	slerr_note_t   nt;
	int            miscompares, samples_checked, lm, n;
	logic [7:0]    rc[7] = '{8'h41, 8'h44, 8'h45, 8'h46, 8'h42, 8'h47, 8'h48};
	logic [7:0]    lc[6] = '{8'h1e, 8'h1f, 8'h15, 8'h16, 8'h1d, 8'h7f};
	logic [7:0]    ec[4] = '{8'h17, 8'h18, 8'h19, 8'h17};

	slerr_reporter #(.CTS_CYCLES(20)) i_slerr_reporter (
		.i_clk(clk), .i_rst_n(rst_n), .i_role(role), .i_enq_limit(lim), .i_req_valid(rv),
		.i_req_starts_conv(st), .i_req_cmd_known(kn), .i_req_perm(perm), .i_req_len_ok(lok),
		.i_req_target_ok(tok), .i_req_values_ok(vok), .i_conv_done(done), .i_phase(ph),
		.i_phase_timeout(tmo), .i_enq_sent(enq), .i_ack_rx(1'b0), .i_nak_rx(nak),
		.i_line_err(le), .i_cpu_xfer_err(ce), .i_misc_err(me), .i_tx_pending(tx), .i_cts(cts),
		.o_req_accept(acc), .o_err_valid(ev), .o_abort(ab), .o_port_busy(busy),
		.o_status_word(sw), .o_diag_word(dw)
	);
	slerr_peer_model i_slerr_peer_model (
		.i_clk(clk), .i_nak_cmd(nakc), .i_cts_block(blk), .o_nak(nak), .o_cts(cts)
	);

	task automatic check(input string nm, input logic [15:0] s, input logic [15:0] e);
		samples_checked++;
		if (s !== e) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask : check
	task automatic close_out;
		$display("checked %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : close_out
	task automatic drain;
		for (int i = 0; i < 300 && q.size() > 0; i++) @(posedge clk);
		if (q.size() > 0) begin
			miscompares++;
			close_out;
		end
	endtask : drain
	// pulses last one edge, then a random idle gap
	task automatic step;
		@(posedge clk);
		{rv, st, tmo, le, ce, me, nakc, done} <= '0;
		{kn, lok, tok, vok} <= '1;
		perm <= SLERR_ANY;
		repeat ($urandom_range(3, 1)) @(posedge clk);
	endtask : step
	task automatic fire(input logic a, input logic [7:0] c);
		q.push_back('{a, c});
		step;
	endtask : fire
	task automatic open_c;
		rv <= 1'b1;
		st <= 1'b1;
		fire(1'b0, 8'h00);
	endtask : open_c

	always @(posedge clk) begin
		if (acc === 1'b1 || ev === 1'b1) begin
			if (q.size() > 0) begin
				nt = q.pop_front();
			end else begin
				nt = '{1'b0, 8'hee};
			end
			check("accept", {15'h0, acc}, {15'h0, nt.code === 8'h00});
			check("abort", {15'h0, ab}, {15'h0, nt.abt});
			if (ev === 1'b1) begin
				check("status", sw, {nt.code, 8'h00});
				check("diag", dw, {8'h00, nt.code});
			end
		end
	end

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	initial begin
		{rst_n, rv, st, done, tmo, enq, le, ce, me, tx, nakc, blk} = '0;
		{kn, lok, tok, vok} = '1;
		lim = 8'h00;
		role = SLERR_MASTER;
		perm = SLERR_ANY;
		ph = SLERR_LS_IDLE;
		miscompares = 0;
		samples_checked = 0;
		void'($urandom(90));
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		open_c;
		check("busy", {15'h0, busy}, 16'h0001);
		rv <= 1'b1;
		st <= 1'b1;
		fire(1'b0, 8'h30);
		done <= 1'b1;
		step;
		open_c;
		for (int k = 0; k < 7; k++) begin
			rv <= 1'b1;
			kn <= (k != 0);
			lok <= (k != 4);
			tok <= (k != 5);
			vok <= (k != 6);
			role <= (k == 2) ? SLERR_SLAVE : SLERR_PEER;
			perm <= (k == 1) ? SLERR_NO_PEER : (k == 2) ? SLERR_NO_SLAVE :
				(k == 3) ? SLERR_MST_ONLY_CMD : SLERR_ANY;
			fire(1'b0, rc[k]);
		end
		// close the conversation so each link fault below starts from a free port
		done <= 1'b1;
		step;
		check("busy", {15'h0, busy}, 16'h0000);
		for (int k = 0; k < 6; k++) begin
			open_c;
			ph <= (k == 0) ? SLERR_LS_HDR : (k == 1) ? SLERR_LS_DATA :
				(k == 2) ? SLERR_LS_WAIT_EOT : (k == 3) ? SLERR_LS_WAIT_ACK : SLERR_LS_IDLE;
			le <= (k < 2);
			tmo <= (k == 2 || k == 3);
			ce <= (k == 4);
			me <= (k == 5);
			fire(1'b1, lc[k]);
		end
		open_c;
		tx <= 1'b1;
		blk <= 1'b1;
		q.push_back('{1'b1, 8'h1a});
		drain;
		tx <= 1'b0;
		blk <= 1'b0;
		lm = $urandom_range(8, 2);
		for (int k = 0; k < 4; k++) begin
			role <= (k == 1 || k == 2) ? SLERR_PEER : SLERR_MASTER;
			lim <= (k == 3) ? 8'h00 : lm[7:0];
			open_c;
			n = (k == 3) ? 32 : lm;
			for (int i = 1; i <= n; i++) begin
				ph <= SLERR_LS_ENQ;
				enq <= 1'b1;
				nakc <= (k == 1);
				tmo <= (k != 1);
				if (i < n) begin
					step;
				end else begin
					fire(1'b1, ec[k]);
				end
			end
			drain;
		end
		close_out;
	end
endmodule : testbench
`default_nettype wire
